//--- inc/cilm_regs.vh
// Constants for the clock input and lock monitor block
`ifndef CILM_REGS_VH
`define CILM_REGS_VH
`define CILM_ADDR_W 4
// Register word offsets
`define CILM_A_CTRL 4'h0
`define CILM_A_REF0_CFG 4'h1
`define CILM_A_REF1_CFG 4'h2
`define CILM_A_VALTIME 4'h3
`define CILM_A_FDET_THR 4'h4
`define CILM_A_LOCK_THR 4'h5
`define CILM_A_STATUS 4'h6
`define CILM_A_REF_STATUS 4'h7
// Ref config field positions
`define CILM_F_FDET_EN 0
`define CILM_F_MISS_EN 1
`define CILM_F_EARLY_EN 2
`define CILM_F_PPS_EN 3
`define CILM_F_AVG_LO 4
`define CILM_F_AVG_HI 5
`define CILM_F_NOM_LO 8
`define CILM_F_NOM_HI 23
`define CILM_F_WIN_LO 24
`define CILM_F_WIN_HI 31
// Ctrl field positions
`define CILM_F_BYP 0
`define CILM_F_SEL 1
`define CILM_F_RES_MON 2
// Reset values
`define CILM_RST_CFG 32'h0000_0000
`define CILM_RST_VALTIME 32'h0000_0010
`define CILM_RST_FDET_THR 32'h0064_0032
`define CILM_RST_LOCK_THR 32'h0064_0032
// Oscillator coarse check bounds in MHz
`define CILM_OSC_MIN_MHZ 9
`define CILM_OSC_MAX_MHZ 160
// Oscillator measurement window: 1 us of clk_sys at 50 MHz
`define CILM_OSC_WIN_NS 1000
`define CILM_CLK_NS 20
`endif

//--- rtl/cilm_ref_win.v
// Late/early and 1-PPS window detector for one reference input
`default_nettype none
module cilm_ref_win
(
  input wire clk_sys,
  input wire srst,
  input wire ref_edge,
  input wire miss_en,
  input wire early_en,
  input wire pps_en,
  input wire [15:0] nom_period,
  input wire [7:0] win_margin,
  output reg window_flag_r
);

  reg [16:0] cnt_r;
  wire [16:0] late_lim;
  wire [16:0] early_lim;
  wire active;

  // Late limit serves both missing-pulse and PPS jitter margin
  assign late_lim = {1'b0, nom_period} + {9'h0_00, win_margin};
  assign early_lim = (nom_period > {8'h00, win_margin}) ? {1'b0, nom_period - {8'h00, win_margin}} : 17'h0_0000;
  assign active = miss_en | pps_en;

  // ----------------------------------------------------------------
  // Window counter and flag
  // ----------------------------------------------------------------
  // Counter saturates at the late limit so a dead input keeps the flag high
  always @(posedge clk_sys)
  begin
    if (srst || !active)
    begin
      cnt_r <= 17'h0_0000;
      window_flag_r <= 1'b0;
    end
    else if (ref_edge)
    begin
      cnt_r <= 17'h0_0000;
      if (early_en && miss_en && !pps_en && cnt_r < early_lim)
        window_flag_r <= 1'b1;
      else
        window_flag_r <= 1'b0;
    end
    else if (cnt_r >= late_lim)
      window_flag_r <= 1'b1;
    else
      cnt_r <= cnt_r + 17'h0_0001;
  end

endmodule
`default_nettype wire

//--- rtl/cilm_top.v
// Clock input qualification and PLL lock monitor
// Functional notes
// - Oscillator loss clears only within 9-160 MHz.
// - Bypass makes oscillator valid, flag unchanged.
// - Qualify after enabled monitors clear validation time.
// - Disabled monitor never flags, excluded from qualification.
// - Ppm detector vs oscillator, hysteresis thresholds.
// - Finer accuracy or averaging lengthens detector delay.
// - Missing pulse flags past nominal plus late.
// - Shared window detector, OR-combined status bit.
// - Early pulse sets flag immediately, later clears.
// - Early detection needs missing detection enabled.
// - PPS window clears on time, sets late.
// - Pins any input; status bits selected only.
// - APLLs frequency lock; DPLL frequency and phase.
// - Resonator monitoring makes DPLL phase-only.
// - DPLL frequency lock with hysteresis thresholds.
// - Resonator lock vs oscillator with hysteresis.
// - DPLL phase lock with lock/unlock thresholds.
`include "cilm_regs.vh"
`default_nettype none
module cilm_top
(
  input wire clk_sys,
  input wire srst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Oscillator pin (asynchronous to clk_sys)
  input wire osc_in,
  // Reference inputs (asynchronous pins)
  input wire [1:0] ref_in,
  // Frequency error measurements (ppm magnitude) and DPLL phase error, from measurement logic
  input wire [1:0] ref_ppm_valid,
  input wire [15:0] ref0_ppm,
  input wire [15:0] ref1_ppm,
  input wire dpll_ppm_valid,
  input wire [15:0] dpll_ppm,
  input wire [15:0] dpll_phase_err,
  input wire [1:0] apll_ppm_valid,
  input wire [15:0] apll0_ppm,
  input wire [15:0] apll1_ppm,
  // Status pins and state machine outputs
  output wire osc_valid,
  output reg osc_freq_loss_flag,
  output wire [1:0] ref_qualified,
  output wire [1:0] ref_freq_error_flag,
  output wire [1:0] ref_window_flag,
  output wire [1:0] apll_loss_of_lock,
  output reg freq_unlock_flag,
  output reg phase_unlock_flag
);

  localparam OSC_WIN_CYC = `CILM_OSC_WIN_NS / `CILM_CLK_NS;
  // Edges counted in one window at the limit frequencies
  localparam [15:0] OSC_MIN_CNT = `CILM_OSC_MIN_MHZ * `CILM_OSC_WIN_NS / 1000;
  localparam [15:0] OSC_MAX_CNT = `CILM_OSC_MAX_MHZ * `CILM_OSC_WIN_NS / 1000;
  localparam ST_IDLE = 2'b00;
  localparam ST_COUNT = 2'b01;
  localparam ST_QUAL = 2'b10;

  // Hysteresis decision used by every ppm detector
  function hyst;
    input cur;
    input [15:0] err;
    input [15:0] lock_thr;
    input [15:0] unlock_thr;
    begin
      if (err < lock_thr)
        hyst = 1'b0;
      else if (err > unlock_thr)
        hyst = 1'b1;
      else
        hyst = cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0] ctrl_r;
  reg [31:0] ref_cfg_r [0:1];
  reg [31:0] valtime_r;
  reg [31:0] fdet_thr_r;
  reg [31:0] lock_thr_r;
  wire osc_detect_bypass = ctrl_r[`CILM_F_BYP];
  wire sel_ref = ctrl_r[`CILM_F_SEL];
  wire res_mon = ctrl_r[`CILM_F_RES_MON];

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_r <= 3'h0;
      ref_cfg_r[0] <= `CILM_RST_CFG;
      ref_cfg_r[1] <= `CILM_RST_CFG;
      valtime_r <= `CILM_RST_VALTIME;
      fdet_thr_r <= `CILM_RST_FDET_THR;
      lock_thr_r <= `CILM_RST_LOCK_THR;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CILM_A_CTRL: ctrl_r <= reg_wdata[2:0];
        `CILM_A_REF0_CFG: ref_cfg_r[0] <= reg_wdata;
        `CILM_A_REF1_CFG: ref_cfg_r[1] <= reg_wdata;
        `CILM_A_VALTIME: valtime_r <= reg_wdata;
        `CILM_A_FDET_THR: fdet_thr_r <= reg_wdata;
        `CILM_A_LOCK_THR: lock_thr_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Oscillator coarse frequency check
  // ----------------------------------------------------------------
  reg [2:0] osc_sync_r;
  reg [15:0] osc_win_r;
  reg [15:0] osc_cnt_r;
  wire osc_rise = osc_sync_r[1] & ~osc_sync_r[2];

  // Sampled edge counting limits this to slow oscillators in simulation;
  // the real detector is analog, so only a coarse answer is needed
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      osc_sync_r <= 3'h0;
      osc_win_r <= 16'h0000;
      osc_cnt_r <= 16'h0000;
      osc_freq_loss_flag <= 1'b1;
    end
    else
    begin
      osc_sync_r <= {osc_sync_r[1:0], osc_in};
      if (osc_win_r == OSC_WIN_CYC[15:0] - 16'h0001)
      begin
        osc_win_r <= 16'h0000;
        osc_cnt_r <= 16'h0000;
        osc_freq_loss_flag <= !(osc_cnt_r >= OSC_MIN_CNT && osc_cnt_r <= OSC_MAX_CNT);
      end
      else
      begin
        osc_win_r <= osc_win_r + 16'h0001;
        if (osc_rise)
          osc_cnt_r <= osc_cnt_r + 16'h0001;
      end
    end
  end

  assign osc_valid = osc_detect_bypass | ~osc_freq_loss_flag;

  // ----------------------------------------------------------------
  // Reference monitors, one set per input
  // ----------------------------------------------------------------
  wire [15:0] ref_ppm [0:1];
  assign ref_ppm[0] = ref0_ppm;
  assign ref_ppm[1] = ref1_ppm;
  wire [1:0] ref_flag_any;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ref
      reg [2:0] sync_r;
      reg fdet_r;
      reg [1:0] avg_cnt_r;
      reg [1:0] state_r;
      reg [31:0] vt_cnt_r;
      wire edge_w = sync_r[1] & ~sync_r[2];
      wire fdet_en = ref_cfg_r[gi][`CILM_F_FDET_EN];
      wire [1:0] avg = ref_cfg_r[gi][`CILM_F_AVG_HI:`CILM_F_AVG_LO];
      // Averaging shortens the usable threshold range
      wire [15:0] thr_lock = fdet_thr_r[15:0] >> avg;
      wire [15:0] thr_unlock = fdet_thr_r[31:16] >> avg;

      always @(posedge clk_sys)
      begin
        if (srst)
          sync_r <= 3'h0;
        else
          sync_r <= {sync_r[1:0], ref_in[gi]};
      end

      // Ppm detector acts only after avg+1 consecutive disagreeing samples
      always @(posedge clk_sys)
      begin
        if (srst || !fdet_en)
        begin
          fdet_r <= 1'b0;
          avg_cnt_r <= 2'b00;
        end
        else if (ref_ppm_valid[gi])
        begin
          if (hyst(fdet_r, ref_ppm[gi], thr_lock, thr_unlock) == fdet_r)
            avg_cnt_r <= 2'b00;
          else if (avg_cnt_r >= avg)
          begin
            fdet_r <= ~fdet_r;
            avg_cnt_r <= 2'b00;
          end
          else
            avg_cnt_r <= avg_cnt_r + 2'b01;
        end
      end

      cilm_ref_win u_win
      (
        .clk_sys(clk_sys),
        .srst(srst),
        .ref_edge(edge_w),
        .miss_en(ref_cfg_r[gi][`CILM_F_MISS_EN]),
        .early_en(ref_cfg_r[gi][`CILM_F_EARLY_EN]),
        .pps_en(ref_cfg_r[gi][`CILM_F_PPS_EN]),
        .nom_period(ref_cfg_r[gi][`CILM_F_NOM_HI:`CILM_F_NOM_LO]),
        .win_margin(ref_cfg_r[gi][`CILM_F_WIN_HI:`CILM_F_WIN_LO]),
        .window_flag_r(ref_window_flag[gi])
      );

      assign ref_freq_error_flag[gi] = fdet_r;
      assign ref_flag_any[gi] = fdet_r | ref_window_flag[gi];

      // Validation timer: qualify after a flag-free stretch
      always @(posedge clk_sys)
      begin
        if (srst)
        begin
          state_r <= ST_IDLE;
          vt_cnt_r <= 32'h0000_0000;
        end
        else
        begin
          case (state_r)
            ST_IDLE:
            begin
              vt_cnt_r <= 32'h0000_0000;
              if (!ref_flag_any[gi])
                state_r <= ST_COUNT;
            end
            ST_COUNT:
            begin
              if (ref_flag_any[gi])
              begin
                state_r <= ST_IDLE;
                vt_cnt_r <= 32'h0000_0000;
              end
              else if (vt_cnt_r >= valtime_r)
                state_r <= ST_QUAL;
              else
                vt_cnt_r <= vt_cnt_r + 32'h0000_0001;
            end
            ST_QUAL:
            begin
              if (ref_flag_any[gi])
                state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
          endcase
        end
      end

      assign ref_qualified[gi] = (state_r == ST_QUAL);
    end
  endgenerate

  // ----------------------------------------------------------------
  // PLL lock detectors
  // ----------------------------------------------------------------
  wire [1:0] apll_lol;
  wire [15:0] apll_ppm [0:1];
  assign apll_ppm[0] = apll0_ppm;
  assign apll_ppm[1] = apll1_ppm;

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_apll
      // One flop per loop so each bit has a single driving process
      reg lol_r;
      // APLL0 is the resonator loop, measured against the oscillator
      always @(posedge clk_sys)
      begin
        if (srst)
          lol_r <= 1'b1;
        else if (apll_ppm_valid[gi])
          lol_r <= hyst(lol_r, apll_ppm[gi], lock_thr_r[15:0], lock_thr_r[31:16]);
      end
      assign apll_lol[gi] = lol_r;
    end
  endgenerate

  assign apll_loss_of_lock = apll_lol;

  // DPLL frequency and phase lock; resonator mode leaves phase only
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      freq_unlock_flag <= 1'b1;
      phase_unlock_flag <= 1'b1;
    end
    else
    begin
      if (res_mon)
        freq_unlock_flag <= 1'b0;
      else if (dpll_ppm_valid)
        freq_unlock_flag <= hyst(freq_unlock_flag, dpll_ppm, lock_thr_r[15:0], lock_thr_r[31:16]);
      phase_unlock_flag <= hyst(phase_unlock_flag, dpll_phase_err, fdet_thr_r[15:0], fdet_thr_r[31:16]);
    end
  end

  // ----------------------------------------------------------------
  // Read path: reference status bits follow the selected reference only
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CILM_A_CTRL: reg_rdata <= {29'h0000_0000, ctrl_r};
        `CILM_A_REF0_CFG: reg_rdata <= ref_cfg_r[0];
        `CILM_A_REF1_CFG: reg_rdata <= ref_cfg_r[1];
        `CILM_A_VALTIME: reg_rdata <= valtime_r;
        `CILM_A_FDET_THR: reg_rdata <= fdet_thr_r;
        `CILM_A_LOCK_THR: reg_rdata <= lock_thr_r;
        `CILM_A_STATUS: reg_rdata <= {26'h000_0000, apll_lol, phase_unlock_flag, freq_unlock_flag,
          osc_valid, osc_freq_loss_flag};
        `CILM_A_REF_STATUS: reg_rdata <= {29'h0000_0000, ref_qualified[sel_ref],
          ref_window_flag[sel_ref], ref_freq_error_flag[sel_ref]};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

//--- test/cilm_properties.sv
// Port-level checker for the clock input and lock monitor
`default_nettype none
module cilm_properties
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] dpll_phase_err,
  input wire logic osc_valid,
  input wire logic osc_freq_loss_flag,
  input wire logic [1:0] ref_qualified,
  input wire logic [1:0] ref_freq_error_flag,
  input wire logic [1:0] ref_window_flag,
  input wire logic [1:0] apll_loss_of_lock,
  input wire logic freq_unlock_flag,
  input wire logic phase_unlock_flag
);
  logic [2:0] ctl_r;
  logic [31:0] thr_r;
  logic en0_r;
  logic [7:0] clean_r;
  // Shadow the writes the checks depend on; thresholds start at reset values
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctl_r <= 3'h0;
      thr_r <= 32'h0064_0032;
      en0_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == 4'h0)
      ctl_r <= reg_wdata[2:0];
    else if (reg_wr && reg_addr == 4'h1)
      en0_r <= reg_wdata[0];
    else if (reg_wr && reg_addr == 4'h4)
      thr_r <= reg_wdata;
  end
  // Cycles with input 0 free of flags; saturates so it never wraps to zero
  always @(posedge clk_sys)
  begin
    if (srst || ref_freq_error_flag[0] || ref_window_flag[0])
      clean_r <= 8'h00;
    else if (clean_r != 8'hff)
      clean_r <= clean_r + 8'h01;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_osc_valid_good: assert property (!osc_freq_loss_flag |-> osc_valid)
    else $error("osc_valid low with good oscillator");
  a_qual_after_clean: assert property ($rose(ref_qualified[0]) |-> clean_r >= 8'h10)
    else $error("input qualified too early");
  a_qual_drops_flag: assert property (ref_freq_error_flag[0] || ref_window_flag[0] |-> ##[0:3] !ref_qualified[0])
    else $error("qualified despite flag");
  a_fdet_off_quiet: assert property (!en0_r && $past(!en0_r) |-> !$rose(ref_freq_error_flag[0]))
    else $error("disabled detector raised flag");
  a_phase_unlock_set: assert property ((dpll_phase_err > thr_r[31:16])[*3] |-> phase_unlock_flag)
    else $error("phase unlock not set");
  a_phase_lock_clr: assert property ((dpll_phase_err < thr_r[15:0])[*3] |-> !phase_unlock_flag)
    else $error("phase unlock not cleared");
  a_res_no_funlock: assert property (ctl_r[2] [*3] |-> !freq_unlock_flag)
    else $error("frequency unlock in resonator mode");
  a_status_read: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata[5:0] ==
    $past({apll_loss_of_lock, phase_unlock_flag, freq_unlock_flag, osc_valid, osc_freq_loss_flag}))
    else $error("status word wrong");
  a_ref_stat_read: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata[2:0] ==
    $past({ref_qualified[ctl_r[1]], ref_window_flag[ctl_r[1]], ref_freq_error_flag[ctl_r[1]]}))
    else $error("reference status wrong");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  c_qual: cover property ($rose(ref_qualified[0]));
  c_win: cover property ($rose(ref_window_flag[0]));
  c_phase: cover property ($fell(phase_unlock_flag));
endmodule
bind cilm_top cilm_properties u_props (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .dpll_phase_err(dpll_phase_err), .osc_valid(osc_valid), .osc_freq_loss_flag(osc_freq_loss_flag),
  .ref_qualified(ref_qualified), .ref_freq_error_flag(ref_freq_error_flag),
  .ref_window_flag(ref_window_flag), .apll_loss_of_lock(apll_loss_of_lock),
  .freq_unlock_flag(freq_unlock_flag), .phase_unlock_flag(phase_unlock_flag));
`default_nettype wire

//--- test/cilm_src.sv
// Oscillator and reference pulse sources for the monitor
`default_nettype none
module cilm_src
(
  input wire logic clk_sys,
  input wire logic [15:0] osc_half,
  input wire logic [15:0] per0,
  input wire logic [15:0] per1,
  output var logic osc_in,
  output var logic [1:0] ref_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int c0 = 0;
  int c1 = 0;
  // A zero half period stops the oscillator low, as a dead crystal would
  initial
  begin
    osc_in = 1'b0;
    forever
    begin
      if (osc_half == 16'h0000)
        #20 osc_in = 1'b0;
      else
        #(osc_half) osc_in = ~osc_in;
    end
  end
  // One-cycle pulses skewed off the edge; a zero period silences the input
  always @(posedge clk_sys)
  begin
    c0 <= (c0 + 1 >= per0) ? 0 : c0 + 1;
    c1 <= (c1 + 1 >= per1) ? 0 : c1 + 1;
    ref_in <= #3 {per1 != 0 && c1 == 0, per0 != 0 && c0 == 0};
  end
endmodule
`default_nettype wire

//--- test/cilm_top_tb.sv
// Self-checking bench for the clock input and lock monitor
`default_nettype none
module cilm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] pv = 5'h00;
  logic [15:0] pw [5] = '{default: 16'h0000};
  logic [15:0] perr = 16'hffff;
  logic [15:0] osc_half = 16'h0000;
  logic [15:0] per0 = 16'h0064;
  logic [15:0] per1 = 16'h0000;
  logic [4:0] st = 5'b01110;
  int cnt [5] = '{default: 0};
  int av = 0;
  int checked = 0;
  int n_mismatch = 0;
  logic [31:0] rs = 32'h6661;
  logic [15:0] ph [6] = '{16'h0070, 16'h0040, 16'h0031, 16'h0064, 16'h0065, 16'h0032};
  logic [5:0] pe = 6'b110011;
  wire logic [31:0] reg_rdata;
  wire logic osc_in, osc_valid, osc_freq_loss_flag, freq_unlock_flag, phase_unlock_flag;
  wire logic [1:0] ref_in, ref_qualified, ref_freq_error_flag, ref_window_flag, apll_loss_of_lock;
  wire logic [4:0] obs = {ref_window_flag, ref_qualified, osc_freq_loss_flag};
  wire logic [4:0] pfl = {ref_freq_error_flag[1], apll_loss_of_lock, freq_unlock_flag, ref_freq_error_flag[0]};
  cilm_top u_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_in(osc_in), .ref_in(ref_in),
    .ref_ppm_valid({pv[4], pv[0]}), .ref0_ppm(pw[0]), .ref1_ppm(pw[4]), .dpll_ppm_valid(pv[1]),
    .dpll_ppm(pw[1]), .dpll_phase_err(perr), .apll_ppm_valid(pv[3:2]), .apll0_ppm(pw[2]),
    .apll1_ppm(pw[3]), .osc_valid(osc_valid), .osc_freq_loss_flag(osc_freq_loss_flag),
    .ref_qualified(ref_qualified), .ref_freq_error_flag(ref_freq_error_flag),
    .ref_window_flag(ref_window_flag), .apll_loss_of_lock(apll_loss_of_lock),
    .freq_unlock_flag(freq_unlock_flag), .phase_unlock_flag(phase_unlock_flag));
  cilm_src u_src (.clk_sys(clk_sys), .osc_half(osc_half), .per0(per0), .per1(per1),
    .osc_in(osc_in), .ref_in(ref_in));
  // 50 MHz system clock
  initial
  begin
    forever
      #10 clk_sys = ~clk_sys;
  end
  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic finish_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Strobes drop for one cycle between accesses so no signal is driven twice per step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    // Read data stand for one cycle only: look at them mid-cycle, clear of both edges
    @(negedge clk_sys);
    chk($sformatf("reg %h", a), e, reg_rdata);
    cyc(1);
  endtask
  // Bounded wait on a status level; running out counts and ends the run
  task automatic wt(input int k, input logic v);
    for (int i = 0; i < 3000 && obs[k] !== v; i++)
      cyc(1);
    chk($sformatf("status %0d", k), {31'h0, v}, {31'h0, obs[k]});
    if (obs[k] !== v)
      finish_test();
  endtask
  // Hysteresis model: a flag moves after avg+1 disagreeing samples
  task automatic pp(input int k, input logic [31:0] r);
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] v;
    logic w;
    lo = 16'h0032 >> (k == 0 ? av : 0);
    hi = 16'h0064 >> (k == 0 ? av : 0);
    v = r[2] ? {9'h000, r[14:8]} : (r[1] ? hi + {15'h0, r[0]} : lo - {15'h0, r[0]});
    w = (k == 4) ? st[k] : (v < lo ? 1'b0 : (v > hi ? 1'b1 : st[k]));
    cnt[k] = (w != st[k]) ? cnt[k] + 1 : 0;
    if (cnt[k] > (k == 0 ? av : 0))
    begin
      st[k] = w;
      cnt[k] = 0;
    end
    pw[k] <= v;
    pv <= 5'h01 << k;
    cyc(1);
    pv <= 5'h00;
    cyc(2);
    chk($sformatf("ppm flag %0d", k), {31'h0, st[k]}, {31'h0, pfl[k]});
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    cyc(12);
    srst <= 1'b0;
    rdchk(4'h6, 32'h0000_003d);
    rdchk(4'h3, 32'h0000_0010);
    rdchk(4'h5, 32'h0064_0032);
    wr(4'hf, 32'hffff_ffff);
    rdchk(4'hf, 32'h0000_0000);
    osc_half <= 16'd50;
    wt(0, 1'b0);
    osc_half <= 16'd125;
    wt(0, 1'b1);
    wr(4'h0, 32'h0000_0001);
    chk("osc_valid", 32'h1, {31'h0, osc_valid});
    chk("osc loss", 32'h1, {31'h0, osc_freq_loss_flag});
    wr(4'h0, 32'h0000_0000);
    osc_half <= 16'd50;
    wt(0, 1'b0);
    wr(4'h1, 32'h0a00_6403);
    for (int i = 0; i < 400; i++)
    begin
      rs = xs(rs);
      if (i == 200)
      begin
        pp(0, 32'h4);
        av = 1;
        wr(4'h1, 32'h0a00_6413);
      end
      pp(rs[18:16] % 5, rs);
    end
    pp(0, 32'h4);
    pp(0, 32'h4);
    per0 <= 16'd80;
    cyc(400);
    chk("early off", 32'h0, {31'h0, ref_window_flag[0]});
    wr(4'h1, 32'h0a00_6407);
    wt(3, 1'b1);
    per0 <= 16'd100;
    wt(3, 1'b0);
    wt(1, 1'b1);
    per0 <= 16'd0;
    wt(3, 1'b1);
    cyc(4);
    chk("qual drop", 32'h0, {31'h0, ref_qualified[0]});
    per0 <= 16'd100;
    wt(1, 1'b1);
    wr(4'h2, 32'h0a00_6408);
    wt(4, 1'b1);
    per1 <= 16'd100;
    wt(4, 1'b0);
    cyc(250);
    chk("pps on time", 32'h0, {31'h0, ref_window_flag[1]});
    chk("pps qual", 32'h1, {31'h0, ref_qualified[1]});
    per1 <= 16'd0;
    wt(4, 1'b1);
    wr(4'h0, 32'h0000_0002);
    rdchk(4'h7, 32'h0000_0002);
    wr(4'h0, 32'h0000_0000);
    rdchk(4'h7, 32'h0000_0004);
    foreach (ph[j])
    begin
      perr <= ph[j];
      cyc(4);
      chk("phase unlock", {31'h0, pe[j]}, {31'h0, phase_unlock_flag});
    end
    pp(1, 32'h2);
    wr(4'h0, 32'h0000_0004);
    cyc(3);
    chk("resonator funlock", 32'h0, {31'h0, freq_unlock_flag});
    finish_test();
  end
endmodule
`default_nettype wire
